// >>> test_uier_top.sv
// Self-checking bench for the user input event reporter
`timescale 1ns/1ps
module test_uier_top;
  import uier_pkg::*;
  localparam int ROW_CYC_SIM = 4;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic [4:0] row_drive, col_sense, key_buf_count, keymap_idx;
  logic       auto_send_en, proto_serial, poll_req, keymap_wr, touch_region_mode;
  logic       touch_sample, touch_ready, region_wr, region_del, region_del_all;
  logic       tx_valid, tx_ready, tx_proto_serial, slow, key_on;
  logic [7:0] keymap_code, touch_x, touch_y, touch_pressure, pressure_thr, drag_thr, tx_data;
  logic [7:0] region_x, region_y, region_w, region_h, region_down, region_up;
  logic [2:0] region_idx, key_row, key_col;
  int         failures = 0;
  int         checks = 0;
  logic [7:0] coord_exp[9] = '{8'h01, 8'h0A, 8'h14, 8'h04, 8'h30, 8'h24, 8'h02, 8'h30, 8'h24};

  uier_top #(.ROW_CYC_P(ROW_CYC_SIM)) i_dut (
    .clk_sys(clk_sys), .resetn(resetn), .row_drive(row_drive), .col_sense(col_sense),
    .auto_send_en(auto_send_en), .proto_serial(proto_serial), .poll_req(poll_req),
    .keymap_wr(keymap_wr), .keymap_idx(keymap_idx), .keymap_code(keymap_code),
    .touch_region_mode(touch_region_mode), .touch_sample(touch_sample), .touch_x(touch_x),
    .touch_y(touch_y), .touch_pressure(touch_pressure), .pressure_thr(pressure_thr),
    .drag_thr(drag_thr), .touch_ready(touch_ready), .region_wr(region_wr),
    .region_del(region_del), .region_del_all(region_del_all), .region_idx(region_idx),
    .region_x(region_x), .region_y(region_y), .region_w(region_w), .region_h(region_h),
    .region_down(region_down), .region_up(region_up), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .tx_proto_serial(tx_proto_serial),
    .key_buf_count(key_buf_count));

  uier_far_model i_far (
    .clk_sys(clk_sys), .row_drive(row_drive), .col_sense(col_sense), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .slow(slow), .key_on(key_on),
    .key_row(key_row), .key_col(key_col));

  always #4 clk_sys = ~clk_sys;

  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick

  // Bounded wait for the next byte the host received
  task automatic expect_byte(input logic [7:0] exp);
    int n;
    n = 0;
    while (i_far.rx_q.size() == 0 && n < 400)
    begin
      tick(1);
      n++;
    end
    if (i_far.rx_q.size() == 0)
      check(~exp, exp);
    else
      check(i_far.rx_q.pop_front(), exp);
  endtask : expect_byte

  // Nothing further may arrive
  task automatic expect_quiet();
    tick(150);
    check(8'(i_far.rx_q.size()), 8'h00);
  endtask : expect_quiet

  // Release waits long enough for the debouncer to see it stable
  task automatic key(input int idx, input logic [7:0] exp, input logic auto_on);
    @(posedge clk_sys);
    key_row <= 3'(idx / 5);
    key_col <= 3'(idx % 5);
    key_on <= 1'b1;
    if (auto_on)
      expect_byte(exp);
    else
      tick(200);
    @(posedge clk_sys);
    key_on <= 1'b0;
    tick(200);
  endtask : key

  task automatic touch(input logic [7:0] x, input logic [7:0] y, input logic [7:0] p);
    @(posedge clk_sys);
    touch_x <= x;
    touch_y <= y;
    touch_pressure <= p;
    touch_sample <= 1'b1;
    @(posedge clk_sys);
    touch_sample <= 1'b0;
  endtask : touch

  task automatic region(input logic [2:0] i, input logic [7:0] x, input logic [7:0] y,
                        input logic [7:0] w, input logic [7:0] h, input logic [7:0] d,
                        input logic [7:0] u);
    @(posedge clk_sys);
    {region_idx, region_x, region_y, region_w, region_h, region_down, region_up} <=
      {i, x, y, w, h, d, u};
    region_wr <= 1'b1;
    @(posedge clk_sys);
    region_wr <= 1'b0;
  endtask : region

  initial
  begin
    #200000;
    failures++;
    final_report();
  end

  initial
  begin
    {auto_send_en, proto_serial, slow, key_on, poll_req, keymap_wr} = 6'b111000;
    {touch_region_mode, touch_sample, region_wr, region_del, region_del_all} = 5'h00;
    {keymap_idx, keymap_code, key_row, key_col, region_idx} = '0;
    {touch_x, touch_y, touch_pressure, region_x, region_y, region_w, region_h} = '0;
    {region_down, region_up} = 16'h0000;
    pressure_thr = 8'h20;
    drag_thr = 8'h10;
    tick(3);
    check({tx_valid, touch_ready, tx_proto_serial, key_buf_count}, 8'h60);
    check({3'h0, row_drive}, 8'h01);
    resetn <= 1'b1;
    tick(4);
    key(7, 8'h48, 1'b1);
    key(24, 8'h59, 1'b1);
    expect_quiet();
    @(posedge clk_sys);
    {keymap_idx, keymap_code, keymap_wr} <= {5'd24, 8'hA5, 1'b1};
    @(posedge clk_sys);
    keymap_wr <= 1'b0;
    key(24, 8'hA5, 1'b1);
    $display("test keys done");
    auto_send_en <= 1'b0;
    key(3, 8'h44, 1'b0);
    key(12, 8'h4D, 1'b0);
    check({3'h0, key_buf_count}, 8'h02);
    expect_quiet();
    repeat (2)
    begin
      @(posedge clk_sys);
      poll_req <= 1'b1;
      @(posedge clk_sys);
      poll_req <= 1'b0;
    end
    expect_byte(8'h44);
    expect_byte(8'h4D);
    check({3'h0, key_buf_count}, 8'h00);
    auto_send_en <= 1'b1;
    $display("test poll done");
    slow <= 1'b0;
    touch(8'h0A, 8'h14, 8'h10);
    touch(8'h0A, 8'h14, 8'h80);
    touch(8'h12, 8'h14, 8'h80);
    touch(8'h30, 8'h24, 8'h80);
    touch(8'h31, 8'h24, 8'h05);
    foreach (coord_exp[i])
      expect_byte(coord_exp[i]);
    expect_quiet();
    $display("test coordinate done");
    touch_region_mode <= 1'b1;
    region(3'h0, 8'h10, 8'h10, 8'h20, 8'h20, 8'h11, 8'h22);
    region(3'h1, 8'h08, 8'h08, 8'h40, 8'h40, 8'h33, 8'h44);
    touch(8'h18, 8'h18, 8'h80);
    touch(8'h30, 8'h18, 8'h80);
    touch(8'h30, 8'h18, 8'h05);
    touch(8'h80, 8'h80, 8'h80);
    touch(8'h80, 8'h80, 8'h05);
    expect_byte(8'h11);
    expect_byte(8'h33);
    expect_byte(8'h44);
    expect_byte(8'hFF);
    expect_byte(8'hFF);
    @(posedge clk_sys);
    {region_idx, region_del} <= {3'h1, 1'b1};
    @(posedge clk_sys);
    region_del <= 1'b0;
    touch(8'h30, 8'h18, 8'h80);
    expect_byte(8'hFF);
    touch(8'h30, 8'h18, 8'h05);
    expect_byte(8'hFF);
    region_del_all <= 1'b1;
    @(posedge clk_sys);
    region_del_all <= 1'b0;
    touch(8'h18, 8'h18, 8'h80);
    expect_byte(8'hFF);
    expect_quiet();
    $display("test region done");
    // Two-wire host keeps automatic sending on and never polls
    proto_serial <= 1'b0;
    tick(3);
    check({7'h00, tx_proto_serial}, 8'h00);
    key(1, 8'h42, 1'b1);
    $display("test two-wire done");
    final_report();
  end
endmodule : test_uier_top

// >>> uier_far_model.sv
// Host sink and keypad matrix at the far side of the reporter
`timescale 1ns/1ps
module uier_far_model (
  input  wire logic       clk_sys,
  input  wire logic [4:0] row_drive,
  output logic      [4:0] col_sense,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_data,
  output logic            tx_ready,
  input  wire logic       slow,
  input  wire logic       key_on,
  input  wire logic [2:0] key_row,
  input  wire logic [2:0] key_col
);
  logic [7:0] rx_q[$];

  // Contact closes only the pressed key's column, on its own row only
  always_comb col_sense = (key_on && row_drive[key_row]) ? (5'h01 << key_col) : 5'h00;

  initial tx_ready = 1'b0;

  // Slow host accepts every other cycle to stall the queue
  always @(posedge clk_sys)
  begin
    if (tx_valid && tx_ready)
      rx_q.push_back(tx_data);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
endmodule : uier_far_model

// >>> uier_pkg.sv
// Shared constants and types for the user input event reporter
package uier_pkg;
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          ROW_TIME_NS   = 200000;
  localparam int          ROW_CYC       = (ROW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          DEB_FRAMES    = 4;
  localparam int          N_ROWS        = 5;
  localparam int          N_COLS        = 5;
  localparam int          N_KEYS        = 25;
  localparam int          TXQ_DEPTH     = 16;
  localparam int          KBUF_DEPTH    = 16;
  localparam int          N_REGIONS     = 8;
  localparam int          PUSH_MAX      = 5;
  localparam logic [7:0]  KEY_CODE_BASE = 8'h41;
  localparam logic [7:0]  EV_PRESS      = 8'h01;
  localparam logic [7:0]  EV_RELEASE    = 8'h02;
  localparam logic [7:0]  EV_DRAG       = 8'h04;
  localparam logic [7:0]  REGION_MISS   = 8'hFF;
  localparam logic        PROTO_SERIAL  = 1'b1;
  localparam logic        PROTO_TWI     = 1'b0;

  typedef enum logic [1:0] {
    UIER_TS_UP   = 2'b01,
    UIER_TS_DOWN = 2'b10
  } uier_touch_e;
endpackage : uier_pkg

// >>> uier_top.sv
// Keypad scanner and touch event reporter feeding a byte transmit queue
`timescale 1ns/1ps
module uier_top
  import uier_pkg::*;
#(
  parameter int ROW_CYC_P  = ROW_CYC,
  parameter int TXQ_D      = TXQ_DEPTH,
  parameter int KBUF_D     = KBUF_DEPTH,
  parameter int NREG       = N_REGIONS
)(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  output logic [4:0]       row_drive,
  input  wire logic [4:0]  col_sense,
  input  wire logic        auto_send_en,
  input  wire logic        proto_serial,
  input  wire logic        poll_req,
  input  wire logic        keymap_wr,
  input  wire logic [4:0]  keymap_idx,
  input  wire logic [7:0]  keymap_code,
  input  wire logic        touch_region_mode,
  input  wire logic        touch_sample,
  input  wire logic [7:0]  touch_x,
  input  wire logic [7:0]  touch_y,
  input  wire logic [7:0]  touch_pressure,
  input  wire logic [7:0]  pressure_thr,
  input  wire logic [7:0]  drag_thr,
  output logic             touch_ready,
  input  wire logic        region_wr,
  input  wire logic        region_del,
  input  wire logic        region_del_all,
  input  wire logic [2:0]  region_idx,
  input  wire logic [7:0]  region_x,
  input  wire logic [7:0]  region_y,
  input  wire logic [7:0]  region_w,
  input  wire logic [7:0]  region_h,
  input  wire logic [7:0]  region_down,
  input  wire logic [7:0]  region_up,
  output logic             tx_valid,
  output logic [7:0]       tx_data,
  input  wire logic        tx_ready,
  output logic             tx_proto_serial,
  output logic [4:0]       key_buf_count
);
  localparam int TW = $clog2(ROW_CYC_P);
  localparam int QW = $clog2(TXQ_D);
  localparam int KW = $clog2(KBUF_D);

  if (ROW_CYC_P < 2 || TXQ_D < 8 || (TXQ_D & (TXQ_D - 1)) != 0 || KBUF_D < 2 ||
      KBUF_D > 16 || (KBUF_D & (KBUF_D - 1)) != 0 || NREG < 1 || NREG > 8)
  begin : g_chk
    $error("uier_top: unsupported parameter values");
  end

  function automatic logic [5:0] first_set(input logic [31:0] v);
    logic [5:0] r;
    r = '0;
    for (int i = 31; i >= 0; i--)
      if (v[i]) r = {1'b1, 5'(i)};
    return r;
  endfunction : first_set

  // Reset release synchroniser
  logic [1:0] rs_r;
  logic       rst_n;
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn) rs_r <= 2'b00;
    else         rs_r <= {rs_r[0], 1'b1};
  assign rst_n = rs_r[1];

  // Key matrix scan and debounce
  logic [TW-1:0]     tmr_r, tmr_nxt;
  logic [2:0]        row_r, row_nxt;
  logic [N_KEYS-1:0] snap_r, snap_nxt, frame_r, frame_nxt, stable_r, stable_nxt;
  logic [N_KEYS-1:0] rep_r, rep_nxt, pend;
  logic [1:0]        deb_r, deb_nxt;
  logic              tick, key_go, auto_eff, space_ok;
  logic [5:0]        key_sel;
  logic [4:0]        key_idx;
  logic [7:0]        keycode_r [N_KEYS];

  assign tick     = tmr_r == TW'(ROW_CYC_P - 1);
  assign pend     = stable_r & ~rep_r;
  assign key_sel  = first_set({7'h00, pend});
  assign key_idx  = key_sel[4:0];
  assign auto_eff = auto_send_en | (proto_serial == PROTO_TWI);
  logic kbuf_full;
  assign key_go   = key_sel[5] && space_ok && (auto_eff || !kbuf_full);

  always_comb
  begin
    tmr_nxt    = tick ? '0 : tmr_r + 1'b1;
    row_nxt    = row_r;
    snap_nxt   = snap_r;
    frame_nxt  = frame_r;
    deb_nxt    = deb_r;
    stable_nxt = stable_r;
    if (tick)
    begin
      snap_nxt[row_r*N_COLS +: N_COLS] = col_sense;
      if (row_r == 3'(N_ROWS - 1))
      begin
        row_nxt   = '0;
        frame_nxt = snap_nxt;
        // Only a frame repeated DEB_FRAMES times is trusted
        if (snap_nxt != frame_r) deb_nxt = '0;
        else if (deb_r != 2'(DEB_FRAMES - 1)) deb_nxt = deb_r + 1'b1;
        else stable_nxt = snap_nxt;
      end
      else row_nxt = row_r + 1'b1;
    end
    rep_nxt = rep_r & stable_r;
    if (key_go) rep_nxt[key_idx] = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      tmr_r <= '0; row_r <= '0; snap_r <= '0; frame_r <= '0;
      deb_r <= '0; stable_r <= '0; rep_r <= '0; row_drive <= 5'h01;
    end
    else
    begin
      tmr_r <= tmr_nxt; row_r <= row_nxt; snap_r <= snap_nxt; frame_r <= frame_nxt;
      deb_r <= deb_nxt; stable_r <= stable_nxt; rep_r <= rep_nxt;
      row_drive <= 5'h01 << row_nxt;
    end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
      for (int i = 0; i < N_KEYS; i++) keycode_r[i] <= KEY_CODE_BASE + 8'(i);
    else if (keymap_wr && keymap_idx < 5'(N_KEYS))
      keycode_r[keymap_idx] <= keymap_code;

  // Poll buffer for key codes
  logic [7:0]  kmem [KBUF_D];
  logic [KW-1:0] kwr_r, krd_r;
  logic [4:0]  kcnt_r;
  logic        kpush, poll_go;
  assign kbuf_full = kcnt_r == 5'(KBUF_D);
  assign kpush     = key_go && !auto_eff;
  assign poll_go   = poll_req && proto_serial && kcnt_r != '0 && space_ok;
  assign key_buf_count = kcnt_r;

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      kwr_r <= '0; krd_r <= '0; kcnt_r <= '0;
    end
    else
    begin
      if (kpush) kwr_r <= kwr_r + 1'b1;
      if (poll_go) krd_r <= krd_r + 1'b1;
      kcnt_r <= kcnt_r + 5'(kpush) - 5'(poll_go);
    end
  always_ff @(posedge clk_sys)
    if (kpush) kmem[kwr_r] <= keycode_r[key_idx];

  // Touch event tracker
  uier_touch_e ts_r, ts_nxt;
  logic [7:0]  lx_r, lx_nxt, ly_r, ly_nxt, ax, ay, ev_type, ev_x, ev_y;
  logic        over, ev_valid, take;
  assign take        = touch_sample && space_ok;
  assign touch_ready = space_ok;
  assign over = touch_pressure > pressure_thr;
  assign ax   = touch_x > lx_r ? touch_x - lx_r : lx_r - touch_x;
  assign ay   = touch_y > ly_r ? touch_y - ly_r : ly_r - touch_y;

  always_comb
  begin
    ts_nxt = ts_r; lx_nxt = lx_r; ly_nxt = ly_r;
    ev_valid = 1'b0; ev_type = EV_PRESS; ev_x = touch_x; ev_y = touch_y;
    case (ts_r)
      UIER_TS_UP:
        if (take && over)
        begin
          ev_valid = 1'b1; ts_nxt = UIER_TS_DOWN; lx_nxt = touch_x; ly_nxt = touch_y;
        end
      UIER_TS_DOWN:
        if (take && !over)
        begin
          ev_valid = 1'b1; ev_type = EV_RELEASE; ev_x = lx_r; ev_y = ly_r;
          ts_nxt = UIER_TS_UP;
        end
        else if (take && (ax > drag_thr || ay > drag_thr))
        begin
          ev_valid = 1'b1; ev_type = EV_DRAG; lx_nxt = touch_x; ly_nxt = touch_y;
        end
      default: ts_nxt = UIER_TS_UP;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      ts_r <= UIER_TS_UP; lx_r <= '0; ly_r <= '0;
    end
    else
    begin
      ts_r <= ts_nxt; lx_r <= lx_nxt; ly_r <= ly_nxt;
    end

  // Region table and hit test
  logic [7:0]      rx [NREG], ry [NREG], rw [NREG], rh [NREG], rdn [NREG], rup [NREG];
  logic [NREG-1:0] rv_r, rv_nxt, hit;
  logic [5:0]      hsel;
  logic [7:0]      rbyte;
  logic            ridx_ok;

  // Widened so that a full table of eight still accepts index 7
  assign ridx_ok = {1'b0, region_idx} < 4'(NREG);

  for (genvar g = 0; g < NREG; g++)
  begin : g_hit
    assign hit[g] = rv_r[g] && ev_x >= rx[g] && {1'b0, ev_x} < {1'b0, rx[g]} + {1'b0, rw[g]}
                 && ev_y >= ry[g] && {1'b0, ev_y} < {1'b0, ry[g]} + {1'b0, rh[g]};
  end
  assign hsel  = first_set(32'(hit));
  assign rbyte = !hsel[5] ? REGION_MISS :
                 ev_type == EV_RELEASE ? rup[hsel[2:0]] : rdn[hsel[2:0]];

  always_comb
  begin
    rv_nxt = rv_r;
    if (region_del_all) rv_nxt = '0;
    else if (region_del && ridx_ok) rv_nxt[region_idx] = 1'b0;
    else if (region_wr && ridx_ok) rv_nxt[region_idx] = 1'b1;
  end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      rv_r <= '0;
      for (int i = 0; i < NREG; i++)
      begin
        rx[i] <= '0; ry[i] <= '0; rw[i] <= '0; rh[i] <= '0; rdn[i] <= '0; rup[i] <= '0;
      end
    end
    else
    begin
      rv_r <= rv_nxt;
      if (region_wr && ridx_ok)
      begin
        rx[region_idx] <= region_x; ry[region_idx] <= region_y;
        rw[region_idx] <= region_w; rh[region_idx] <= region_h;
        rdn[region_idx] <= region_down; rup[region_idx] <= region_up;
      end
    end

  // Transmit byte queue; oldest event first within a cycle
  logic [7:0]  txq [TXQ_D];
  logic [7:0]  pb [PUSH_MAX];
  logic [2:0]  push_n;
  logic [QW-1:0] wr_r, rd_r;
  logic [QW:0] cnt_r, cnt_nxt;
  logic        pop;
  assign space_ok = cnt_r <= (QW+1)'(TXQ_D - PUSH_MAX);
  assign tx_valid = cnt_r != '0;
  assign tx_data  = txq[rd_r];
  assign pop      = tx_valid && tx_ready;

  always_comb
  begin
    push_n = '0;
    for (int i = 0; i < PUSH_MAX; i++) pb[i] = '0;
    if (poll_go)
    begin
      pb[push_n] = kmem[krd_r]; push_n = push_n + 1'b1;
    end
    if (key_go && auto_eff)
    begin
      pb[push_n] = keycode_r[key_idx]; push_n = push_n + 1'b1;
    end
    if (ev_valid && touch_region_mode)
    begin
      pb[push_n] = rbyte; push_n = push_n + 1'b1;
    end
    else if (ev_valid)
    begin
      pb[push_n] = ev_type; pb[push_n+1] = ev_x; pb[push_n+2] = ev_y;
      push_n = push_n + 3'd3;
    end
    cnt_nxt = cnt_r + (QW+1)'(push_n) - (QW+1)'(pop);
  end

  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n)
    begin
      wr_r <= '0; rd_r <= '0; cnt_r <= '0; tx_proto_serial <= PROTO_SERIAL;
    end
    else
    begin
      wr_r <= wr_r + QW'(push_n); rd_r <= rd_r + QW'(pop); cnt_r <= cnt_nxt;
      tx_proto_serial <= proto_serial;
    end
  always_ff @(posedge clk_sys)
    for (int i = 0; i < PUSH_MAX; i++)
      if (3'(i) < push_n) txq[QW'(wr_r + QW'(i))] <= pb[i];

  // Checks
  property p_row_onehot;
    @(posedge clk_sys) disable iff (!rst_n) $onehot(row_drive) && row_drive == 5'h01 << row_r;
  endproperty
  a_row_onehot: assert property (p_row_onehot) else $error("row drive not one-hot");
  property p_auto_send;
    @(posedge clk_sys) disable iff (!rst_n) key_go && auto_eff && !poll_go |->
      pb[0] == keycode_r[key_idx] ##1 tx_valid;
  endproperty
  a_auto_send: assert property (p_auto_send) else $error("auto key not queued");
  property p_buffer;
    @(posedge clk_sys) disable iff (!rst_n) key_go && !auto_eff && !poll_go |=>
      kcnt_r == $past(kcnt_r) + 5'd1;
  endproperty
  a_buffer: assert property (p_buffer) else $error("key not buffered");
  property p_coord;
    @(posedge clk_sys) disable iff (!rst_n) ev_valid && !touch_region_mode |->
      (pb[push_n-3] == EV_PRESS || pb[push_n-3] == EV_RELEASE || pb[push_n-3] == EV_DRAG)
      && pb[push_n-1] == ev_y;
  endproperty
  a_coord: assert property (p_coord) else $error("bad coordinate report");
  property p_miss;
    @(posedge clk_sys) disable iff (!rst_n) ev_valid && touch_region_mode && hit == '0 |->
      pb[push_n-1] == 8'hFF;
  endproperty
  a_miss: assert property (p_miss) else $error("miss not reported as 255");
  property p_release_up;
    @(posedge clk_sys) disable iff (!rst_n)
      ev_valid && touch_region_mode && ev_type == EV_RELEASE && hsel[5] |->
      pb[push_n-1] == rup[hsel[2:0]];
  endproperty
  a_release_up: assert property (p_release_up) else $error("release not key-up");
  property p_press_thr;
    @(posedge clk_sys) disable iff (!rst_n) ev_valid && ev_type != EV_RELEASE |->
      touch_pressure > pressure_thr;
  endproperty
  a_press_thr: assert property (p_press_thr) else $error("event under pressure");
  property p_debounce;
    @(posedge clk_sys) disable iff (!rst_n) stable_r != $past(stable_r) |->
      $past(deb_r) == 2'(DEB_FRAMES - 1) && $past(tick);
  endproperty
  a_debounce: assert property (p_debounce) else $error("undebounced key");
  property p_del_all;
    @(posedge clk_sys) disable iff (!rst_n) region_del_all |=> rv_r == '0;
  endproperty
  a_del_all: assert property (p_del_all) else $error("regions not cleared");
  property p_count;
    @(posedge clk_sys) disable iff (!rst_n) 1'b1 |=> cnt_r <= (QW+1)'(TXQ_D);
  endproperty
  a_count: assert property (p_count) else $error("queue count lost bytes");
  c_key: cover property (@(posedge clk_sys) disable iff (!rst_n) key_go && auto_eff);
  c_poll: cover property (@(posedge clk_sys) disable iff (!rst_n) poll_go);
  c_drag: cover property (@(posedge clk_sys) disable iff (!rst_n) ev_valid && ev_type == EV_DRAG);
  c_region: cover property (@(posedge clk_sys) disable iff (!rst_n)
    ev_valid && touch_region_mode && hsel[5]);
endmodule : uier_top
